//--- common/cprc_consts.svh
// Offsets, field positions, reset values and timing counts of the pump regulator control block
// Behaviour
// - Pump and regulator both run only while the pump-regulator enable bit is one.
// - Force-on with enable keeps the pump on; otherwise the auto-mode bit decides.
// - Auto-mode bit one enables automatic pump switching; zero disables it.
// - Bit 3 reads pump running state in auto mode; meaningful only then.
// - Bit 4 enables the excitation voltage output.
// - Bit 5 selects excitation level: zero low level, one high level.
// - Bit 6 enables the analog supply output of the regulator.
// - Bit 7 enables the common-mode reference output.
// - Enable, force-on and auto bits decode into off, always on, automatic, regulator only.
// - Auto mode runs the pump when supply is low, stops it when high.
// - Pump off, regulator on: analog functions available only while supply is high.
// - Clock register holds a write-only four-bit divider select, reset to zero.
// - Pump clock is the instruction clock divided by four, then by two to select.
// - Band-gap enable is bit 6 of the amplifier mode register.
`ifndef CPRC_CONSTS_SVH
`define CPRC_CONSTS_SVH

// Register indices; byte address is four times the index
`define CPRC_IDX_MODE          8'h95
`define CPRC_IDX_CLKSEL        8'h96
`define CPRC_IDX_AMPMODE       8'h90
`define CPRC_ADDR_MODE         10'h254
`define CPRC_ADDR_CLKSEL       10'h258
`define CPRC_ADDR_AMPMODE      10'h240

// Mode register fields
`define CPRC_BIT_REG_EN        0
`define CPRC_BIT_FORCE_ON      1
`define CPRC_BIT_AUTO          2
`define CPRC_BIT_STATE         3
`define CPRC_BIT_EXC_EN        4
`define CPRC_BIT_EXC_SEL       5
`define CPRC_BIT_ASUP_EN       6
`define CPRC_BIT_CM_EN         7
`define CPRC_BIT_BG_EN         6

// Reset values
`define CPRC_MODE_RESET        8'h00
`define CPRC_CLKSEL_RESET      4'h0
`define CPRC_AMPMODE_RESET     8'h0E
`define CPRC_AMPMODE_MASK      8'h7F
`define CPRC_CLKSEL_WIDTH      4

// Fixed predivider and settle time
`define CPRC_PREDIV            4
`define CPRC_CLK_MHZ           200
`define CPRC_SETTLE_MS         30
`define CPRC_SETTLE_CYCLES     (`CPRC_SETTLE_MS * `CPRC_CLK_MHZ * 1000)

`endif

//--- common/cprc_pkg.sv
// Types of the pump regulator control block
package cprc_pkg;

    typedef enum logic [1:0]
    {
        CPRC_PUMP_OFF,
        CPRC_PUMP_ALWAYS,
        CPRC_PUMP_AUTO,
        CPRC_PUMP_REG_ONLY
    } cprc_mode_type;

endpackage

//--- hw/cprc_clkdiv.sv
// Pump clock divider: divide by four, then by a power of two
`timescale 1ns/1ps
`default_nettype none
`include "cprc_consts.svh"

module cprc_clkdiv
#(
    parameter int SEL_W = `CPRC_CLKSEL_WIDTH
)
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Control
    input  wire logic [SEL_W-1:0] sel_i,
    input  wire logic             run_i,
    // Divided clock, gated
    output logic                  pump_clk_o
);
    localparam int CNT_W = 2 + (1 << SEL_W);

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             clk_q;
    logic             clk_d;
    logic [CNT_W-1:0] half;

    always_comb
    begin
        // Half period of Fcpu/4/2^sel in cycles is 2*2^sel
        half  = CNT_W'(1) << (32'(sel_i) + 1);
        cnt_d = cnt_q;
        clk_d = clk_q;
        // Pump clock gating
        if (!run_i)
        begin
            cnt_d = '0;
            clk_d = 1'b0;
        end
        // Clock division chain
        else if (cnt_q >= half - CNT_W'(1))
        begin
            cnt_d = '0;
            clk_d = ~clk_q;
        end
        else
        begin
            cnt_d = cnt_q + CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_q <= '0;
            clk_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            clk_q <= clk_d;
        end
    end

    assign pump_clk_o = clk_q;

endmodule
`default_nettype wire

//--- hw/cprc_mode_dec.sv
// Pump working-mode decoder
`timescale 1ns/1ps
`default_nettype none

module cprc_mode_dec
(
    // Mode bits
    input  wire logic  reg_en_i,
    input  wire logic  force_on_i,
    input  wire logic  auto_i,
    // Mode and regulator demand
    output cprc_pkg::cprc_mode_type mode_o,
    output logic       regulator_on_o
);
    import cprc_pkg::*;

    always_comb
    begin
        // Four-way mode decode
        if (!reg_en_i)
            mode_o = CPRC_PUMP_OFF;
        else if (force_on_i)
            mode_o = CPRC_PUMP_ALWAYS;
        else if (auto_i)
            mode_o = CPRC_PUMP_AUTO;
        else
            mode_o = CPRC_PUMP_REG_ONLY;
        // Enable gates both units
        regulator_on_o = reg_en_i;
    end

endmodule
`default_nettype wire

//--- hw/cprc_top.sv
// Charge pump and regulator control with classic Wishbone register slave
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cprc_consts.svh"

module cprc_top
#(
    parameter int SEL_W = `CPRC_CLKSEL_WIDTH
)
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Comparator
    input  wire logic        supply_high_i,
    // Analog controls
    output logic             pump_run_o,
    output logic             pump_clk_o,
    output logic             regulator_on_o,
    output logic             analog_supply_enable_o,
    output logic             excitation_out_enable_o,
    output logic             excitation_level_select_o,
    output logic             common_mode_enable_o,
    output logic             bandgap_enable_o,
    output logic             analog_ready_o
);
    import cprc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]       mode_q;
    logic [7:0]       mode_d;
    logic [SEL_W-1:0] clksel_q;
    logic [SEL_W-1:0] clksel_d;
    logic [7:0]       amp_q;
    logic [7:0]       amp_d;
    logic             ack_q;
    logic             ack_d;
    logic [31:0]      rdat_q;
    logic [31:0]      rdat_d;
    logic             run_q;
    logic             run_d;
    logic             state_q;
    logic             state_d;
    logic             ready_q;
    logic             ready_d;
    logic             regon_q;
    logic             asup_q;
    logic             exc_en_q;
    logic             exc_sel_q;
    logic             cm_q;
    logic             bg_q;
    logic             req;
    logic             wr;
    logic [7:0]       mode_rd;
    cprc_mode_type    mode;
    logic             reg_on;
    logic             pump_clk;

    assign req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr  = req & wb_we_i & wb_sel_i[0];

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    cprc_mode_dec u_dec
    (
        .reg_en_i       (mode_q[`CPRC_BIT_REG_EN]),
        .force_on_i     (mode_q[`CPRC_BIT_FORCE_ON]),
        .auto_i         (mode_q[`CPRC_BIT_AUTO]),
        .mode_o         (mode),
        .regulator_on_o (reg_on)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pump clock
    cprc_clkdiv #(.SEL_W(SEL_W)) u_div
    (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .sel_i      (clksel_q),
        .run_i      (run_q),
        .pump_clk_o (pump_clk)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register file and bus
    always_comb
    begin
        mode_d   = mode_q;
        clksel_d = clksel_q;
        amp_d    = amp_q;
        ack_d    = req;
        rdat_d   = 32'h0000_0000;
        mode_rd  = mode_q;
        // Live state bit in mode read-back
        mode_rd[`CPRC_BIT_STATE] = state_q;
        if (wr)
        begin
            unique case (wb_adr_i)
                `CPRC_ADDR_MODE:
                begin
                    // Status bit not writable
                    mode_d = wb_dat_i[7:0];
                    mode_d[`CPRC_BIT_STATE] = 1'b0;
                end
                `CPRC_ADDR_CLKSEL: clksel_d = wb_dat_i[SEL_W-1:0];
                `CPRC_ADDR_AMPMODE: amp_d = wb_dat_i[7:0] & `CPRC_AMPMODE_MASK;
                default: ;
            endcase
        end
        if (req && !wb_we_i)
        begin
            unique case (wb_adr_i)
                `CPRC_ADDR_MODE:    rdat_d = {24'h00_0000, mode_rd};
                `CPRC_ADDR_AMPMODE: rdat_d = {24'h00_0000, amp_q};
                default:            rdat_d = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pump decisions
    always_comb
    begin
        run_d   = 1'b0;
        state_d = 1'b0;
        ready_d = 1'b0;
        unique case (mode)
            CPRC_PUMP_OFF:
            begin
                run_d   = 1'b0;
                ready_d = 1'b0;
            end
            CPRC_PUMP_ALWAYS:
            begin
                run_d   = 1'b1;
                ready_d = 1'b1;
            end
            CPRC_PUMP_AUTO:
            begin
                run_d   = ~supply_high_i;
                state_d = ~supply_high_i;
                ready_d = 1'b1;
            end
            // regulator only, supply must be high
            CPRC_PUMP_REG_ONLY:
            begin
                run_d   = 1'b0;
                ready_d = supply_high_i;
            end
        endcase
        if (!mode_q[`CPRC_BIT_ASUP_EN])
            ready_d = 1'b0;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mode_q    <= `CPRC_MODE_RESET;
            clksel_q  <= SEL_W'(`CPRC_CLKSEL_RESET);
            amp_q     <= `CPRC_AMPMODE_RESET;
            ack_q     <= 1'b0;
            rdat_q    <= 32'h0000_0000;
            run_q     <= 1'b0;
            state_q   <= 1'b0;
            ready_q   <= 1'b0;
            regon_q   <= 1'b0;
            asup_q    <= 1'b0;
            exc_en_q  <= 1'b0;
            exc_sel_q <= 1'b0;
            cm_q      <= 1'b0;
            bg_q      <= 1'b0;
        end
        else
        begin
            mode_q    <= mode_d;
            clksel_q  <= clksel_d;
            amp_q     <= amp_d;
            ack_q     <= ack_d;
            rdat_q    <= rdat_d;
            run_q     <= run_d;
            state_q   <= state_d;
            ready_q   <= ready_d;
            regon_q   <= reg_on;
            asup_q    <= mode_q[`CPRC_BIT_ASUP_EN] & reg_on;
            exc_en_q  <= mode_q[`CPRC_BIT_EXC_EN];
            exc_sel_q <= mode_q[`CPRC_BIT_EXC_SEL];
            cm_q      <= mode_q[`CPRC_BIT_CM_EN];
            bg_q      <= amp_q[`CPRC_BIT_BG_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign wb_ack_o                  = ack_q;
    assign wb_dat_o                  = rdat_q;
    assign pump_run_o                = run_q;
    // divide by four and power of two
    assign pump_clk_o                = pump_clk;
    assign regulator_on_o            = regon_q;
    assign analog_supply_enable_o    = asup_q;
    assign excitation_out_enable_o   = exc_en_q;
    assign excitation_level_select_o = exc_sel_q;
    assign common_mode_enable_o      = cm_q;
    assign bandgap_enable_o          = bg_q;
    assign analog_ready_o            = ready_q;

endmodule
`default_nettype wire

//--- verif/cprc_checker_assertions.sv
// Port checker for the pump regulator control block
`timescale 1ns/1ps
`default_nettype none
`include "cprc_consts.svh"

module cprc_checker
#(
    parameter int SEL_W = `CPRC_CLKSEL_WIDTH
)
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // Bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Analog controls
    input wire logic        pump_run_o,
    input wire logic        pump_clk_o,
    input wire logic        regulator_on_o,
    input wire logic        analog_supply_enable_o,
    input wire logic        excitation_out_enable_o
);

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("ack missing after request");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");

    property p_ack_src;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_src: assert property (p_ack_src)
        else $error("ack without request");

    property p_idle_dat;
        !wb_ack_o |-> wb_dat_o == 32'h0;
    endproperty
    a_idle_dat: assert property (p_idle_dat)
        else $error("read data outside ack");

    property p_wo_read;
        wb_ack_o && !wb_we_i && wb_adr_i == `CPRC_ADDR_CLKSEL |-> wb_dat_o == 32'h0;
    endproperty
    a_wo_read: assert property (p_wo_read)
        else $error("clock select readable");

    property p_mode_wr;
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `CPRC_ADDR_MODE |-> ##2
            regulator_on_o == $past(wb_dat_i[0], 2) && excitation_out_enable_o == $past(wb_dat_i[4], 2);
    endproperty
    a_mode_wr: assert property (p_mode_wr)
        else $error("mode write not applied");

    property p_clk_gate;
        !pump_run_o [*3] |-> !pump_clk_o;
    endproperty
    a_clk_gate: assert property (p_clk_gate)
        else $error("pump clock while stopped");

    property p_run_reg;
        pump_run_o |-> regulator_on_o;
    endproperty
    a_run_reg: assert property (p_run_reg)
        else $error("pump runs while disabled");

    property p_asup;
        analog_supply_enable_o |-> regulator_on_o;
    endproperty
    a_asup: assert property (p_asup)
        else $error("supply output while disabled");

endmodule

bind cprc_top cprc_checker #(.SEL_W(SEL_W)) u_chk
(
    .clk_i                   (clk_i),
    .rst_i                   (rst_i),
    .wb_cyc_i                (wb_cyc_i),
    .wb_stb_i                (wb_stb_i),
    .wb_we_i                 (wb_we_i),
    .wb_adr_i                (wb_adr_i),
    .wb_sel_i                (wb_sel_i),
    .wb_dat_i                (wb_dat_i),
    .wb_dat_o                (wb_dat_o),
    .wb_ack_o                (wb_ack_o),
    .pump_run_o              (pump_run_o),
    .pump_clk_o              (pump_clk_o),
    .regulator_on_o          (regulator_on_o),
    .analog_supply_enable_o  (analog_supply_enable_o),
    .excitation_out_enable_o (excitation_out_enable_o)
);

`default_nettype wire

//--- verif/cprc_top_tb_top.sv
// Self-checking bench for the pump regulator control block
`timescale 1ns/1ps
`default_nettype none
`include "cprc_consts.svh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end

module cprc_top_tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, supply_high_i = 1'b0;
    logic [9:0]  wb_adr_i = 10'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdata;
    logic        wb_ack_o, pump_run_o, pump_clk_o, regulator_on_o, analog_supply_enable_o;
    logic        excitation_out_enable_o, excitation_level_select_o, common_mode_enable_o;
    logic        bandgap_enable_o, analog_ready_o;
    logic [7:0]  m_mode = 8'h00;
    logic [6:0]  m_amp = 7'h0E;
    integer      seed = 32'hA1A9;
    int          miscompares = 0;
    int          num_checks = 0;
    time         t0;

    cprc_top dut
    (
        .clk_i                     (clk_i),
        .rst_i                     (rst_i),
        .wb_cyc_i                  (wb_cyc_i),
        .wb_stb_i                  (wb_stb_i),
        .wb_we_i                   (wb_we_i),
        .wb_adr_i                  (wb_adr_i),
        .wb_sel_i                  (wb_sel_i),
        .wb_dat_i                  (wb_dat_i),
        .wb_dat_o                  (wb_dat_o),
        .wb_ack_o                  (wb_ack_o),
        .supply_high_i             (supply_high_i),
        .pump_run_o                (pump_run_o),
        .pump_clk_o                (pump_clk_o),
        .regulator_on_o            (regulator_on_o),
        .analog_supply_enable_o    (analog_supply_enable_o),
        .excitation_out_enable_o   (excitation_out_enable_o),
        .excitation_level_select_o (excitation_level_select_o),
        .common_mode_enable_o      (common_mode_enable_o),
        .bandgap_enable_o          (bandgap_enable_o),
        .analog_ready_o            (analog_ready_o)
    );

    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wb_cycle(input logic we, input logic [9:0] a, input logic [3:0] s, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
        begin
            @(posedge clk_i);
        end
        `CHK("ack", 1'b1, wb_ack_o)
        rdata = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [9:0] a, input logic [3:0] s, input logic [31:0] d);
        wb_cycle(1'b1, a, s, d);
        if (a == `CPRC_ADDR_MODE && s[0])
            m_mode = {d[7:4], 1'b0, d[2:0]};
        if (a == `CPRC_ADDR_AMPMODE && s[0])
            m_amp = d[6:0];
    endtask

    task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
        wb_cycle(1'b0, a, 4'hF, 32'h0);
        `CHK("read", e, rdata)
    endtask

    task automatic check_state();
        logic run;
        logic st;
        repeat (4) @(posedge clk_i);
        run = m_mode[0] & (m_mode[1] | (m_mode[2] & ~supply_high_i));
        st = m_mode[0] & m_mode[2] & ~m_mode[1] & ~supply_high_i;
        `CHK("pump_run", run, pump_run_o)
        `CHK("regulator", m_mode[0], regulator_on_o)
        `CHK("asup", m_mode[6] & m_mode[0], analog_supply_enable_o)
        `CHK("exc_en", m_mode[4], excitation_out_enable_o)
        `CHK("exc_sel", m_mode[5], excitation_level_select_o)
        `CHK("cm_en", m_mode[7], common_mode_enable_o)
        `CHK("bandgap", m_amp[6], bandgap_enable_o)
        `CHK("ready", m_mode[0] & m_mode[6] & (m_mode[1] | m_mode[2] | supply_high_i), analog_ready_o)
        rd_chk(`CPRC_ADDR_MODE, {24'h0, m_mode[7:4], st, m_mode[2:0]});
    endtask

    task automatic pump_period(input int s);
        wr(`CPRC_ADDR_MODE, 4'hF, 32'h03);
        @(posedge pump_clk_o);
        t0 = $time;
        @(posedge pump_clk_o);
        `CHK("period", 32'(4 << s), 32'(($time - t0) / 5))
        @(posedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check_state();
        rd_chk(`CPRC_ADDR_CLKSEL, 32'h0);
        rd_chk(`CPRC_ADDR_AMPMODE, 32'h0E);
        rd_chk(10'h3FC, 32'h0);
        wr(`CPRC_ADDR_AMPMODE, 4'hF, 32'h4E);
        for (int i = 0; i < 48; i++)
        begin
            supply_high_i <= i[3];
            wr(`CPRC_ADDR_MODE, (i < 16) ? 4'hF : 4'($random(seed)), {24'h0, 5'($random(seed)), i[2:0]});
            check_state();
        end
        wr(`CPRC_ADDR_MODE, 4'hF, 32'hC5);
        wr(`CPRC_ADDR_AMPMODE, 4'hF, 32'hFF);
        rd_chk(`CPRC_ADDR_AMPMODE, 32'h7F);
        wr(10'h3FC, 4'hF, 32'hFF);
        check_state();
        for (int s = 0; s < 5; s += 4)
        begin
            wr(`CPRC_ADDR_CLKSEL, 4'hF, 32'(s));
            pump_period(s);
        end
        rd_chk(`CPRC_ADDR_CLKSEL, 32'h0);
        wr(`CPRC_ADDR_MODE, 4'hF, 32'h00);
        repeat (8) @(posedge clk_i);
        `CHK("pump_clk", 1'b0, pump_clk_o)
        wr(`CPRC_ADDR_MODE, 4'hF, 32'hF7);
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        m_mode = 8'h00;
        m_amp = 7'h0E;
        check_state();
        wr(`CPRC_ADDR_AMPMODE, 4'hF, 32'h4E);
        pump_period(0);
        give_verdict();
    end

    initial
    begin
        #200000;
        miscompares++;
        give_verdict();
    end
endmodule

`default_nettype wire
